// ==== shared/sblentry_pkg.sv ====
package sblentry_pkg;
  localparam logic [15:0] SBL_SYSTEM_CONFIG_REG_BOOT = 16'h0e00;
  localparam logic [15:0] SBL_CP_BOOT = 16'hfa00;
  localparam logic [15:0] SBL_SP_BOOT = 16'hfa40;
  localparam logic [15:0] SBL_STACK_UNDERFLOW_LIMIT_BOOT = 16'hfa40;
  localparam logic [15:0] SBL_STACK_OVERFLOW_LIMIT_BOOT = 16'hfa0c;
  localparam logic [15:0] SBL_SCON_BOOT = 16'h8011;
  localparam logic [15:0] SBL_RAM_FIRST = 16'hfa40;
  localparam logic [15:0] SBL_RAM_LAST = 16'hfa5f;
  localparam logic [23:0] SBL_BRANCH_ADDR = 24'h00fa40;
  localparam logic [15:0] SBL_MEAS_SUB = 16'h0024;
  localparam logic [15:0] SBL_MEAS_DIV = 16'h0048;
  localparam int SBL_BLOCK_BYTES = 32;
  localparam int SBL_BAUD_DIV = 32;
  localparam logic [7:0] SBL_FLASH_SEG0 = 8'h00;
  localparam logic [7:0] SBL_FLASH_SEG1 = 8'h01;
  localparam logic [15:0] SBL_FLASH_TOP = 16'h7fff;
  localparam logic [7:0] SBL_ID_DEFAULT = 8'h5a;
  localparam logic [2:0] SBL_OFF_CTRL = 3'h0;
  localparam logic [2:0] SBL_OFF_STATUS = 3'h1;
  localparam logic [2:0] SBL_OFF_BAUD = 3'h2;
  localparam logic [2:0] SBL_OFF_SYSTEM_CONFIG_REG = 3'h3;
  localparam logic [2:0] SBL_OFF_STACK = 3'h4;
  localparam logic [2:0] SBL_OFF_CPSCON = 3'h5;
  typedef enum logic [2:0] {
    SBL_IDLE = 3'b000,
    SBL_WAIT_START = 3'b001,
    SBL_MEASURE = 3'b010,
    SBL_SEND_ID = 3'b011,
    SBL_RECV = 3'b100,
    SBL_DONE = 3'b101
  } sblentry_state_type;
endpackage : sblentry_pkg

// ==== verilog/sblentry_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
module sblentry_ram #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_sys_i, // System clock
  input wire logic we_i, // Write strobe
  input wire logic [AW-1:0] waddr_i, // Write index
  input wire logic [7:0] wdata_i, // Write byte
  input wire logic [AW-1:0] raddr_i, // Read index
  output logic [7:0] rdata_o // Registered read byte
);
  logic [7:0] mem_r [DEPTH];
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end
endmodule : sblentry_ram
`default_nettype wire

// ==== verilog/sblentry_uart.sv ====
`timescale 1ns/1ps
`default_nettype none
// Serial port run from a tick enable, sixteen ticks per bit; rx is already synchronised
module sblentry_uart (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Async reset
  input wire logic [15:0] reload_i, // Baud reload
  input wire logic run_i, // Port enabled
  input wire logic rx_en_i, // Receiver enabled
  input wire logic rx_i, // Synchronised rx level
  input wire logic tx_go_i, // Start sending tx_byte_i
  input wire logic [7:0] tx_byte_i, // Byte to send
  output logic tx_o, // Serial out
  output logic tx_busy_o, // Sending
  output logic rx_valid_o, // Byte received pulse
  output logic [7:0] rx_byte_o // Received byte
);
  import sblentry_pkg::*;
  localparam int SBL_SMP = SBL_BAUD_DIV / 2;
  logic [15:0] pre_r;
  logic tick, half_r;
  logic [4:0] tsub_r, rsub_r;
  logic [3:0] tcnt_r, rcnt_r;
  logic [8:0] tsh_r;
  logic rbusy_r;

  // Sixteen ticks per bit with two-phase reload gives the 32x(reload+1) rate
  assign tick = run_i && (pre_r == 16'h0000) && half_r;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pre_r <= 16'h0000;
      half_r <= 1'b0;
    end else if (!run_i) begin
      pre_r <= reload_i;
      half_r <= 1'b0;
    end else if (pre_r == 16'h0000) begin
      pre_r <= reload_i;
      half_r <= !half_r;
    end else begin
      pre_r <= pre_r - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
      tx_busy_o <= 1'b0;
      tsub_r <= 5'h00;
      tcnt_r <= 4'h0;
      tsh_r <= 9'h1ff;
    end else if (tx_go_i && !tx_busy_o) begin
      tx_busy_o <= 1'b1;
      tsh_r <= {tx_byte_i, 1'b0};
      tcnt_r <= 4'h0;
      tsub_r <= 5'h00;
    end else if (tx_busy_o && tick) begin
      tx_o <= tsh_r[0];
      if (tsub_r == 5'(SBL_SMP - 1)) begin
        tsub_r <= 5'h00;
        tsh_r <= {1'b1, tsh_r[8:1]};
        tcnt_r <= tcnt_r + 4'h1;
        if (tcnt_r == 4'h9) begin
          tx_busy_o <= 1'b0;
        end
      end else begin
        tsub_r <= tsub_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rbusy_r <= 1'b0;
      rsub_r <= 5'h00;
      rcnt_r <= 4'h0;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (!rbusy_r) begin
        if (rx_en_i && !rx_i) begin
          rbusy_r <= 1'b1;
          rsub_r <= 5'h00;
          rcnt_r <= 4'h0;
        end
      end else if (tick) begin
        // Free at mid stop bit so a back-to-back start edge is not missed
        if (rsub_r == 5'(SBL_SMP / 2) && rcnt_r == 4'h9) begin
          rbusy_r <= 1'b0;
        end
        if (rsub_r == 5'(SBL_SMP / 2) && rcnt_r != 4'h0 && rcnt_r != 4'h9) begin
          rx_byte_o <= {rx_i, rx_byte_o[7:1]};
        end
        if (rsub_r == 5'(SBL_SMP - 1)) begin
          rsub_r <= 5'h00;
          rcnt_r <= rcnt_r + 4'h1;
          if (rcnt_r == 4'h8) begin
            rx_valid_o <= 1'b1;
          end
        end else begin
          rsub_r <= rsub_r + 5'h01;
        end
      end
    end
  end
endmodule : sblentry_uart
`default_nettype wire

// ==== verilog/sblentry_top.sv ====
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sblentry_top #(
  parameter logic [7:0] ID_BYTE = sblentry_pkg::SBL_ID_DEFAULT // Arbitrary value
) (
  input wire logic clk_sys_i, // System clock, 10 MHz
  input wire logic rst_i, // Async hardware reset, high
  input wire logic sw_reset_i, // Software reset pulse
  input wire logic boot_strap_pin_i, // Strap pin, low selects boot
  input wire logic external_access_pin_i, // External access pin
  input wire logic [15:0] bus_strap_i, // Startup bus configuration
  input wire logic serial_rx_line_i, // Serial receive pin
  input wire logic flash_seg1_i, // Flash mapped to segment 1
  input wire logic fetch_code_i, // Access is a code fetch
  input wire logic [23:0] fetch_addr_i, // Access address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic boot_loader_mode_o, // Boot loader mode active
  output logic serial_tx_line_o, // Serial transmit pin
  output logic serial_tx_oe_n_o, // Tx output enable, low drives
  output logic watchdog_en_o, // Watchdog enabled
  output logic code_from_bootrom_o, // Access served by boot ROM
  output logic ext_access_sel_o, // Evaluated external access
  output logic ram_we_o, // Internal RAM write strobe
  output logic [15:0] ram_addr_o, // Internal RAM address
  output logic [7:0] ram_wdata_o, // Internal RAM write byte
  output logic branch_o, // Branch to loaded code pulse
  output logic [23:0] branch_addr_o, // Branch target
  output logic [15:0] system_config_reg_o, // System config preset
  output logic [15:0] context_base_pointer_o, // Context base preset
  output logic [15:0] stack_top_pointer_o, // Stack pointer preset
  output logic [15:0] stack_underflow_limit_o, // Underflow preset
  output logic [15:0] stack_overflow_limit_o, // Overflow preset
  output logic [15:0] serial_control_reg_o, // Serial control preset
  output logic [15:0] bus_config_zero_o // Bus config preset
);
  import sblentry_pkg::*;

  sblentry_state_type state_r;
  logic rx_s1_r, rx_s2_r, rx_d_r, strap_s1_r, strap_s2_r, hw_boot_r;
  logic [15:0] edge_measure_timer_r, baud_reload_value_r;
  logic [3:0] edge_cnt_r;
  logic meas_ovf_r, tx_go_r, tx_busy, rx_valid, uart_run_r, rx_en_r;
  logic [7:0] rx_byte, ram_rdata;
  logic [5:0] rx_count_r;
  logic [4:0] peek_idx_r;
  logic apb_acc, addr_ok;

  // Derives the reload from a measured count, saturating at zero
  function automatic logic [15:0] sbl_reload(input logic [15:0] cnt);
    sbl_reload = (cnt > SBL_MEAS_SUB) ? (cnt - SBL_MEAS_SUB) / SBL_MEAS_DIV : 16'h0000;
  endfunction : sbl_reload

  // Pins cross into the clock domain through two stages
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_d_r <= 1'b1;
      strap_s1_r <= 1'b1;
      strap_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= serial_rx_line_i;
      rx_s2_r <= rx_s1_r;
      rx_d_r <= rx_s2_r;
      strap_s1_r <= boot_strap_pin_i;
      strap_s2_r <= strap_s1_r;
    end
  end

  // Second stage holds the pin only two edges after release; bus mode plays no part
  logic strap_taken_r;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      strap_taken_r <= 1'b0;
      hw_boot_r <= 1'b0;
    end else begin
      strap_taken_r <= 1'b1;
      hw_boot_r <= strap_taken_r;
    end
  end

  // Mode flag: set from strap sample, cleared by software reset
  logic strap_done_r;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      strap_done_r <= 1'b0;
      boot_loader_mode_o <= 1'b0;
    end else if (sw_reset_i) begin
      boot_loader_mode_o <= 1'b0;
      strap_done_r <= 1'b1;
    end else if (!strap_done_r && hw_boot_r) begin
      // Synchroniser output settles two edges after release
      strap_done_r <= 1'b1;
      boot_loader_mode_o <= !strap_s2_r;
    end
  end

  // Boot sequence
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= SBL_IDLE;
      edge_measure_timer_r <= 16'h0000;
      edge_cnt_r <= 4'h0;
      meas_ovf_r <= 1'b0;
      baud_reload_value_r <= 16'h0000;
      uart_run_r <= 1'b0;
      tx_go_r <= 1'b0;
      rx_en_r <= 1'b0;
      rx_count_r <= 6'h00;
      serial_tx_oe_n_o <= 1'b1;
      branch_o <= 1'b0;
    end else begin
      tx_go_r <= 1'b0;
      branch_o <= 1'b0;
      case (state_r)
        SBL_IDLE: begin
          if (boot_loader_mode_o) begin
            state_r <= SBL_WAIT_START;
          end
        end
        SBL_WAIT_START: begin
          if (rx_d_r && !rx_s2_r) begin
            edge_measure_timer_r <= 16'h0000;
            edge_cnt_r <= 4'h0;
            meas_ovf_r <= 1'b0;
            state_r <= SBL_MEASURE;
          end
        end
        SBL_MEASURE: begin
          // Quarter-rate enable makes the count 9/4 of a bit time, as the reload formula expects
          edge_cnt_r <= (edge_cnt_r == 4'h3) ? 4'h0 : edge_cnt_r + 4'h1;
          if (edge_cnt_r == 4'h3 && edge_measure_timer_r == 16'hffff) begin
            meas_ovf_r <= 1'b1;
          end else if (edge_cnt_r == 4'h3) begin
            edge_measure_timer_r <= edge_measure_timer_r + 16'h0001;
          end
          if (!rx_d_r && rx_s2_r) begin
            baud_reload_value_r <= sbl_reload(edge_measure_timer_r);
            // An overflowed count leaves the port off and waits for a new zero byte
            uart_run_r <= !meas_ovf_r;
            serial_tx_oe_n_o <= meas_ovf_r;
            tx_go_r <= !meas_ovf_r;
            state_r <= meas_ovf_r ? SBL_WAIT_START : SBL_SEND_ID;
          end
        end
        SBL_SEND_ID: begin
          if (!tx_go_r && !tx_busy) begin
            rx_en_r <= 1'b1;
            rx_count_r <= 6'h00;
            state_r <= SBL_RECV;
          end
        end
        SBL_RECV: begin
          if (rx_valid) begin
            rx_count_r <= rx_count_r + 6'h01;
            if (rx_count_r == 6'(SBL_BLOCK_BYTES - 1)) begin
              branch_o <= 1'b1;
              state_r <= SBL_DONE;
            end
          end
        end
        SBL_DONE: begin
          if (!boot_loader_mode_o) begin
            state_r <= SBL_IDLE;
          end
        end
        default: state_r <= SBL_IDLE;
      endcase
      if (!boot_loader_mode_o && state_r != SBL_IDLE) begin
        state_r <= SBL_IDLE;
        uart_run_r <= 1'b0;
        rx_en_r <= 1'b0;
        serial_tx_oe_n_o <= 1'b1;
      end
    end
  end

  // Received bytes go to consecutive RAM byte addresses from the base
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ram_we_o <= 1'b0;
      ram_addr_o <= SBL_RAM_FIRST;
      ram_wdata_o <= 8'h00;
    end else begin
      ram_we_o <= (state_r == SBL_RECV) && rx_valid;
      ram_addr_o <= SBL_RAM_FIRST + {10'h000, rx_count_r};
      ram_wdata_o <= rx_byte;
    end
  end

  // Presets forced on entry
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_en_o <= 1'b1;
      system_config_reg_o <= 16'h0000;
      context_base_pointer_o <= 16'h0000;
      stack_top_pointer_o <= 16'h0000;
      stack_underflow_limit_o <= 16'h0000;
      stack_overflow_limit_o <= 16'h0000;
      serial_control_reg_o <= 16'h0000;
      bus_config_zero_o <= 16'h0000;
      branch_addr_o <= SBL_BRANCH_ADDR;
      ext_access_sel_o <= 1'b0;
    end else begin
      watchdog_en_o <= !boot_loader_mode_o;
      bus_config_zero_o <= bus_strap_i;
      ext_access_sel_o <= boot_loader_mode_o ? 1'b0 : external_access_pin_i;
      branch_addr_o <= SBL_BRANCH_ADDR;
      if (boot_loader_mode_o) begin
        system_config_reg_o <= SBL_SYSTEM_CONFIG_REG_BOOT;
        context_base_pointer_o <= SBL_CP_BOOT;
        stack_top_pointer_o <= SBL_SP_BOOT;
        stack_underflow_limit_o <= SBL_STACK_UNDERFLOW_LIMIT_BOOT;
        stack_overflow_limit_o <= SBL_STACK_OVERFLOW_LIMIT_BOOT;
        serial_control_reg_o <= SBL_SCON_BOOT;
      end
    end
  end

  // Only code fetches inside the flash window are redirected
  logic [7:0] flash_seg;
  assign flash_seg = flash_seg1_i ? SBL_FLASH_SEG1 : SBL_FLASH_SEG0;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      code_from_bootrom_o <= 1'b0;
    end else begin
      code_from_bootrom_o <= boot_loader_mode_o && fetch_code_i &&
        fetch_addr_i[23:16] == flash_seg && fetch_addr_i[15:0] <= SBL_FLASH_TOP;
    end
  end

  sblentry_uart u_uart (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .reload_i(baud_reload_value_r),
    .run_i(uart_run_r),
    .rx_en_i(rx_en_r),
    .rx_i(rx_s2_r),
    .tx_go_i(tx_go_r),
    .tx_byte_i(ID_BYTE),
    .tx_o(serial_tx_line_o),
    .tx_busy_o(tx_busy),
    .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte)
  );

  // Shadow copy of the loaded block for software read-back
  sblentry_ram u_ram (
    .clk_sys_i(clk_sys_i),
    .we_i(state_r == SBL_RECV && rx_valid),
    .waddr_i(rx_count_r[4:0]),
    .wdata_i(rx_byte),
    .raddr_i(peek_idx_r),
    .rdata_o(ram_rdata)
  );

  // APB: one wait state so the registered read data is ready
  assign apb_acc = psel && penable && !pready;
  assign addr_ok = paddr[31:5] == 27'h0 && paddr[1:0] == 2'b00 && paddr[4:2] <= SBL_OFF_CPSCON;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      peek_idx_r <= 5'h00;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc && !addr_ok;
      if (apb_acc && pwrite && addr_ok && paddr[4:2] == SBL_OFF_CTRL) begin
        peek_idx_r <= pwdata[4:0];
      end
      if (apb_acc && !pwrite && addr_ok) begin
        case (paddr[4:2])
          SBL_OFF_CTRL: prdata <= {19'h0, ram_rdata, peek_idx_r};
          SBL_OFF_STATUS: prdata <= {19'h0, meas_ovf_r, rx_count_r, state_r,
            boot_loader_mode_o, watchdog_en_o, serial_tx_oe_n_o};
          SBL_OFF_BAUD: prdata <= {edge_measure_timer_r, baud_reload_value_r};
          SBL_OFF_SYSTEM_CONFIG_REG: prdata <= {bus_config_zero_o, system_config_reg_o};
          SBL_OFF_STACK: prdata <= {stack_overflow_limit_o, stack_underflow_limit_o};
          SBL_OFF_CPSCON: prdata <= {context_base_pointer_o, serial_control_reg_o};
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (apb_acc) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  sequence s_last_byte;
    state_r == SBL_RECV && rx_valid && rx_count_r == 6'd31;
  endsequence
  AST_BRANCH_AFTER_32: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_last_byte |=> branch_o && state_r == SBL_DONE) else $error("no branch after 32 bytes");
  AST_NO_WDOG: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    boot_loader_mode_o |=> !watchdog_en_o) else $error("watchdog on in boot mode");
  AST_SYSTEM_CONFIG_REG: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    boot_loader_mode_o |=> system_config_reg_o == 16'h0e00 && stack_top_pointer_o == 16'hfa40)
    else $error("bad presets");
  AST_STACK_OVERFLOW_LIMIT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    boot_loader_mode_o |=> stack_overflow_limit_o == 16'hfa0c && serial_control_reg_o == 16'h8011)
    else $error("bad overflow or serial preset");
  AST_EA_IGN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    boot_loader_mode_o |=> !ext_access_sel_o) else $error("external access used");
  AST_REDIRECT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    code_from_bootrom_o |-> $past(boot_loader_mode_o) && $past(fetch_code_i))
    else $error("redirect outside code fetch");
  AST_SWRST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sw_reset_i |=> !boot_loader_mode_o) else $error("mode kept after soft reset");
  AST_TX_QUIET: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r == SBL_RECV |-> !tx_busy) else $error("tx during receive");
  AST_RAM_ADDR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ram_we_o |-> ram_addr_o >= 16'hfa40 && ram_addr_o <= 16'hfa5f) else $error("ram addr range");
endmodule : sblentry_top
`default_nettype wire

// ==== dv/sblentry_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sblentry_host (
  input wire logic clk_i, // Bench clock
  input wire logic tx_i, // Device tx line, pulled high
  output logic rx_o // Line into the device
);
  initial rx_o = 1'b1;
  // One 8N1 frame, LSB first; line rests high after the stop bit
  task automatic send_byte(input logic [7:0] b, input int bitclk);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o <= f[i];
      repeat (bitclk) @(posedge clk_i);
    end
  endtask : send_byte
  // Listen only, never drive: half duplex is enough
  task automatic recv_byte(output logic [7:0] b, input int bitclk, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (tx_i !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n < 20000) begin
      repeat (bitclk + bitclk / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        b[i] = tx_i;
        repeat (bitclk) @(posedge clk_i);
      end
      ok = (tx_i === 1'b1);
    end
  endtask : recv_byte
endmodule : sblentry_host
`default_nettype wire

// ==== dv/sblentry_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sblentry_top_tb;
  import sblentry_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic sw_reset_i = 1'b0;
  logic boot_strap_pin_i = 1'b0;
  logic external_access_pin_i = 1'b1;
  logic [15:0] bus_strap_i = 16'h0000;
  logic flash_seg1_i = 1'b0;
  logic fetch_code_i = 1'b0;
  logic [23:0] fetch_addr_i = 24'h000000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, ok;
  logic boot_loader_mode_o, serial_tx_line_o, serial_tx_oe_n_o, watchdog_en_o;
  logic code_from_bootrom_o, ext_access_sel_o, ram_we_o, branch_o;
  logic [15:0] ram_addr_o, system_config_reg_o, context_base_pointer_o, stack_top_pointer_o;
  logic [15:0] stack_underflow_limit_o, stack_overflow_limit_o, serial_control_reg_o;
  logic [15:0] bus_config_zero_o;
  logic [7:0] ram_wdata_o, idb;
  logic [23:0] branch_addr_o;
  logic [7:0] exp_b [32];
  logic [31:0] lf;
  wire serial_rx_line_i;
  wire txl;
  int num_errors = 0;
  int num_checks = 0;
  int nwr = 0;
  int nbr = 0;
  int k, db;
  // Pull-up holds the tx line high while the device leaves it undriven
  assign txl = serial_tx_oe_n_o ? 1'b1 : serial_tx_line_o;
  always #50 clk_sys_i = ~clk_sys_i;
  sblentry_top dut_u (.clk_sys_i, .rst_i, .sw_reset_i, .boot_strap_pin_i,
    .external_access_pin_i, .bus_strap_i, .serial_rx_line_i, .flash_seg1_i,
    .fetch_code_i, .fetch_addr_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .boot_loader_mode_o, .serial_tx_line_o,
    .serial_tx_oe_n_o, .watchdog_en_o, .code_from_bootrom_o, .ext_access_sel_o,
    .ram_we_o, .ram_addr_o, .ram_wdata_o, .branch_o, .branch_addr_o,
    .system_config_reg_o, .context_base_pointer_o, .stack_top_pointer_o,
    .stack_underflow_limit_o, .stack_overflow_limit_o, .serial_control_reg_o,
    .bus_config_zero_o);
  sblentry_host host_u (.clk_i(clk_sys_i), .tx_i(txl), .rx_o(serial_rx_line_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
    if (n >= 50) chk("apb_wait", 0, 1);
  endtask : apb
  task automatic fetch(input logic c, input logic s, input logic [23:0] a, input logic e);
    fetch_code_i <= c;
    flash_seg1_i <= s;
    fetch_addr_i <= a;
    repeat (2) @(posedge clk_sys_i);
    chk("bootrom", e, code_from_bootrom_o);
  endtask : fetch
  always @(posedge clk_sys_i) begin
    if (ram_we_o === 1'b1) begin
      chk("ram_addr", SBL_RAM_FIRST + nwr, ram_addr_o);
      chk("ram_data", exp_b[nwr], ram_wdata_o);
      nwr++;
    end
    if (branch_o === 1'b1) begin
      chk("branch_addr", SBL_BRANCH_ADDR, branch_addr_o);
      nbr++;
    end
  end
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    chk("timeout", 0, 1);
    end_sim();
  end
  initial begin
    lf = 32'h20;
    for (int i = 0; i < 40; i++) lf = lfsr(lf);
    bus_strap_i = lf[15:0];
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk("mode", 1, boot_loader_mode_o);
    chk("bus_cfg", bus_strap_i, bus_config_zero_o);
    chk("wdog", 0, watchdog_en_o);
    chk("ext_sel", 0, ext_access_sel_o);
    chk("sysconf", SBL_SYSTEM_CONFIG_REG_BOOT, system_config_reg_o);
    chk("cp", SBL_CP_BOOT, context_base_pointer_o);
    chk("sp", SBL_SP_BOOT, stack_top_pointer_o);
    chk("stack_underflow_limit", SBL_STACK_UNDERFLOW_LIMIT_BOOT, stack_underflow_limit_o);
    chk("stack_overflow_limit", SBL_STACK_OVERFLOW_LIMIT_BOOT, stack_overflow_limit_o);
    chk("scon", SBL_SCON_BOOT, serial_control_reg_o);
    chk("oe_n", 1, serial_tx_oe_n_o);
    fetch(1'b1, 1'b0, {9'h0, lf[30:16]}, 1'b1);
    fetch(1'b0, 1'b0, {9'h0, lf[30:16]}, 1'b0);
    fetch(1'b1, 1'b1, {9'h2, lf[30:16]}, 1'b1);
    fetch(1'b1, 1'b1, {9'h0, lf[30:16]}, 1'b0);
    fetch(1'b0, 1'b0, 24'h0, 1'b0);
    apb(1'b0, 32'h0c, 32'h0);
    chk("reg_busconf", {bus_strap_i, SBL_SYSTEM_CONFIG_REG_BOOT}, rd);
    apb(1'b0, 32'h18, 32'h0);
    chk("unmapped_err", 1, er);
    // Bit time 32*(k+1) puts the quarter-rate count midway between reload steps
    k = lf[1:0];
    db = 32 * (k + 1);
    fork
      host_u.send_byte(8'h00, db);
      host_u.recv_byte(idb, db, ok);
    join
    chk("id_stop", 1, ok);
    chk("id_byte", SBL_ID_DEFAULT, idb);
    apb(1'b0, 32'h08, 32'h0);
    chk("reload", k, rd[15:0]);
    repeat (db) @(posedge clk_sys_i);
    for (int i = 0; i < 32; i++) begin
      lf = lfsr(lf);
      exp_b[i] = lf[7:0];
      host_u.send_byte(exp_b[i], db);
    end
    // One byte past the block must not land in RAM
    host_u.send_byte(8'h33, db);
    repeat (4) @(posedge clk_sys_i);
    chk("writes", 32, nwr);
    chk("branches", 1, nbr);
    apb(1'b1, 32'h00, 32'h5);
    apb(1'b0, 32'h00, 32'h0);
    chk("peek", exp_b[5], rd[12:5]);
    chk("mode_kept", 1, boot_loader_mode_o);
    sw_reset_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_reset_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk("mode_sw", 0, boot_loader_mode_o);
    chk("wdog_sw", 1, watchdog_en_o);
    chk("ext_sel_sw", 1, ext_access_sel_o);
    boot_strap_pin_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk("mode_hw", 0, boot_loader_mode_o);
    fetch(1'b1, 1'b0, 24'h001000, 1'b0);
    end_sim();
  end
endmodule : sblentry_top_tb
`default_nettype wire
